// *** design/wds_top.sv ***
// waveform sequencer: register file, rate divider, buffer sequencer,
// converter serial links, sram arbitration and flash access
// assumes host strobes, sram and flash data are synchronous to I_REF_CLK
//
// Overview of operation
// - sample rate is 32 MHz divided by divisor plus two.
// - position register shows next buffer offset; low 11 bits matter.
// - final point register holds last valid offset; low 11 bits matter.
// - with auto update set, direct writes also drive the output at once.
// - sequencer enable reloads holding stage from sram on each sample tick.
// - source select picks divider ticks or update strobe writes as ticks.
// - with match enable set, position equal to match point raises interrupt.
// - read busy bit reads one while a converter read-back is running.
// - coding select chooses offset binary or two's complement input.
// - at buffer end the sequencer stops or wraps to zero.
// - reload strobe restarts the divider count from the divisor.
// - position clear strobe zeroes the buffer position counter.
// - zero strobe clears holding stage and drives outputs to zero volts.
// - update strobe gives one manual tick updating all outputs together.
// - access register write shifts 24 bits out; read shows ready (not busy) in MSB.
// - data passes through a holding stage before the output stage.
// - sram sits at 0x00000 to 0x1ffff, 1024 words per channel.
// - host sram accesses win; the sequencer waits for a free slot.
// - flash sits on even bytes 0x20000 to 0x23ffe.
// - flash write ends on bit 7 poll or timeout; no write meanwhile.
// - each tick updates outputs, then with sequencer enable set fetches 48 words into holding.
// - first point shows at the second tick, last one tick after stop.
// - serial word is 4 command bits, 4 unused, 16 data bits.
`timescale 1ns/1ps
`default_nettype none
module wds_top #(
  parameter int SER_DIV = wds_pkg::SER_DIV,
  parameter logic [15:0] FLASH_TIMEOUT_CYC = 16'(wds_pkg::FLASH_WRITE_CYC)
) (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic I_IO_SEL,
  input wire logic I_MEM_SEL,
  input wire logic I_WR_EN,
  input wire logic I_RD_EN,
  input wire logic [17:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic [15:0] I_SRAM_RDATA,
  input wire logic [7:0] I_FLASH_RDATA,
  input wire logic [2:0] I_CONV_SDO,
  output logic [15:0] O_RDATA,
  output logic O_ACK,
  output logic O_HOST_IRQ,
  output logic [15:0] O_SRAM_ADDR,
  output logic [15:0] O_SRAM_WDATA,
  output logic O_SRAM_WE,
  output logic [12:0] O_FLASH_ADDR,
  output logic [7:0] O_FLASH_WDATA,
  output logic O_FLASH_WE_N,
  output logic O_FLASH_OE_N,
  output logic [2:0] O_CONV_SCLK,
  output logic [2:0] O_CONV_SYNC_N,
  output logic [2:0] O_CONV_SDI,
  output logic [767:0] O_CHAN_DATA
);
  localparam int NCH = wds_pkg::NCH;
  localparam int NCONV = wds_pkg::NCONV;

  typedef struct packed {
    wds_pkg::wds_host_t hs;
    logic ack;
    logic [15:0] rdata;
    logic [15:0] wcnt;
    logic [31:0] div_n;
    logic [31:0] div_cnt;
    logic [6:0] acc;
    logic [15:0] pos;
    logic [15:0] last;
    logic [15:0] match;
    logic [7:0] ctrl;
    logic irq;
    logic [NCH-1:0][15:0] hold;
    logic [NCH-1:0][15:0] outv;
    logic fetch;
    logic [5:0] fch;
    logic p1v;
    logic p2v;
    logic [5:0] p1ch;
    logic [5:0] p2ch;
    logic [15:0] saddr;
    logic [15:0] swd;
    logic swe;
    logic [NCONV-1:0][15:0] alo;
    logic [NCONV-1:0][7:0] ahi;
    logic [NCONV-1:0][23:0] sh;
    logic [NCONV-1:0][4:0] bitc;
    logic [NCONV-1:0] sbusy;
    logic [NCONV-1:0] sclk;
    logic [NCONV-1:0] syn_n;
    logic [NCONV-1:0] sdi;
    logic [NCONV-1:0][15:0] rb;
    logic [NCONV-1:0] sd1;
    logic [NCONV-1:0] sd2;
    logic [NCONV-1:0] sd3;
    logic [NCONV-1:0] sdf;
    logic [3:0] sdiv;
    logic [12:0] faddr;
    logic [7:0] fwd;
    logic fwe_n;
    logic foe_n;
    logic frd;
    logic fbusy;
    logic fbit7;
    logic [15:0] fto;
  } wds_state_t;

  wds_state_t q;
  wds_state_t d;

  // output stage always carries offset binary, so signed input flips MSB
  function automatic logic [15:0] code16(input logic [15:0] v,
                                         input logic sgn);
    return sgn ? {~v[15], v[14:0]} : v;
  endfunction

  function automatic logic [1:0] acc_idx(input logic [6:0] ad);
    return 2'((ad - wds_pkg::OFF_ACC) >> 2);
  endfunction

  function automatic logic [1:0] rb_idx(input logic [6:0] ad);
    return 2'((ad - wds_pkg::OFF_RB) >> 1);
  endfunction

  logic req;
  logic io_wr;
  logic io_rd;
  logic ctrl_wr;
  logic dir_wr;
  logic host_sram;
  logic t32;
  logic div_tick;
  logic tick;
  logic upd_wr;
  logic ser_en;
  logic seq_end;
  logic [7:0] acc_n;
  logic [6:0] a;
  logic [5:0] dch;
  logic [NCONV-1:0] ser_start;

  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.swe = 1'b0;
    d.p1v = 1'b0;
    d.p2v = q.p1v;
    d.p2ch = q.p1ch;
    ser_start = '0;
    a = I_ADDR[6:0];
    dch = 6'((a - wds_pkg::OFF_DIRECT) >> 1);
    req = (I_IO_SEL | I_MEM_SEL) & (I_WR_EN | I_RD_EN) &
          (q.hs == wds_pkg::H_IDLE);
    io_wr = req & I_IO_SEL & I_WR_EN;
    io_rd = req & I_IO_SEL & !I_WR_EN;
    ctrl_wr = io_wr && a == wds_pkg::OFF_CTRL;
    dir_wr = io_wr && a >= wds_pkg::OFF_DIRECT;
    host_sram = req & !I_IO_SEL & (I_ADDR <= wds_pkg::SRAM_TOP);
    upd_wr = ctrl_wr && I_WDATA[wds_pkg::CB_UPD];

    // 32 MHz reference emulated by a fractional accumulator
    acc_n = 8'(q.acc) + 8'(wds_pkg::OSC_MHZ);
    t32 = acc_n >= 8'(wds_pkg::CLK_MHZ);
    d.acc = t32 ? 7'(acc_n - 8'(wds_pkg::CLK_MHZ)) : acc_n[6:0];
    div_tick = 1'b0;
    if (ctrl_wr && I_WDATA[wds_pkg::CB_RELOAD]) begin
      d.div_cnt = q.div_n + 32'd1;
    end else if (t32) begin
      if (q.div_cnt == '0) begin
        div_tick = 1'b1;
        d.div_cnt = q.div_n + 32'd1;
      end else begin
        d.div_cnt = q.div_cnt - 32'd1;
      end
    end
    tick = q.ctrl[wds_pkg::CB_INT_SRC] ? div_tick : upd_wr;

    if (tick || upd_wr) begin
      for (int i = 0; i < NCH; i++) begin
        d.outv[i] = code16(q.hold[i], q.ctrl[wds_pkg::CB_SIGNED]);
      end
    end

    // sequencer fetch: one sram read per free slot, host has priority
    seq_end = 1'b0;
    if (q.fetch && !host_sram) begin
      d.saddr = {q.fch, q.pos[9:0]};
      d.p1v = 1'b1;
      d.p1ch = q.fch;
      d.fch = q.fch + 6'd1;
      if (q.fch == 6'(NCH - 1)) begin
        d.fetch = 1'b0;
        if ((q.pos & wds_pkg::POS_MASK) ==
            (q.last & wds_pkg::POS_MASK)) begin
          seq_end = 1'b1;
          if (q.ctrl[wds_pkg::CB_STOP]) begin
            d.ctrl[wds_pkg::CB_SEQ] = 1'b0;
          end else begin
            d.pos = '0;
          end
        end else begin
          d.pos = q.pos + 16'd1;
        end
      end
    end
    if (tick && q.ctrl[wds_pkg::CB_SEQ]) begin
      d.fetch = 1'b1;
      d.fch = '0;
    end
    if (q.p2v) begin
      d.hold[q.p2ch] = I_SRAM_RDATA;
    end

    // converter serial links
    d.sd1 = I_CONV_SDO;
    d.sd2 = q.sd1;
    d.sd3 = q.sd2;
    ser_en = (q.sdiv == 4'(SER_DIV - 1));
    d.sdiv = ser_en ? '0 : q.sdiv + 4'd1;
    for (int i = 0; i < NCONV; i++) begin
      if (q.sd2[i] == q.sd3[i]) begin
        d.sdf[i] = q.sd3[i];
      end
      if (q.sbusy[i] && ser_en) begin
        if (!q.sclk[i]) begin
          d.sclk[i] = 1'b1;
        end else begin
          // sampled at the fall: the input filter delays sdo by 4 cycles
          d.sclk[i] = 1'b0;
          d.rb[i] = {q.rb[i][14:0], q.sdf[i]};
          if (q.bitc[i] == 5'd1) begin
            d.sbusy[i] = 1'b0;
            d.syn_n[i] = 1'b1;
          end else begin
            d.bitc[i] = q.bitc[i] - 5'd1;
            d.sh[i] = {q.sh[i][22:0], 1'b0};
            d.sdi[i] = q.sh[i][22];
          end
        end
      end
    end

    // flash write guard: cleared by timeout or by a matching poll
    if (q.fbusy) begin
      if (q.fto == '0) begin
        d.fbusy = 1'b0;
      end else begin
        d.fto = q.fto - 16'd1;
      end
    end

    case (q.hs)
      wds_pkg::H_SR1: begin
        d.hs = wds_pkg::H_SR2;
      end
      wds_pkg::H_SR2: begin
        d.rdata = I_SRAM_RDATA;
        d.ack = 1'b1;
        d.hs = wds_pkg::H_IDLE;
      end
      wds_pkg::H_FL: begin
        if (q.wcnt == '0) begin
          d.fwe_n = 1'b1;
          d.foe_n = 1'b1;
          d.ack = 1'b1;
          d.hs = wds_pkg::H_IDLE;
          if (q.frd) begin
            d.rdata = {8'h00, I_FLASH_RDATA};
            if (q.fbusy && I_FLASH_RDATA[7] == q.fbit7) begin
              d.fbusy = 1'b0;
            end
          end else begin
            // the write time runs from the end of the strobe
            d.fto = FLASH_TIMEOUT_CYC;
          end
        end else begin
          d.wcnt = q.wcnt - 16'd1;
        end
      end
      default: begin
      end
    endcase

    if (req) begin
      d.ack = 1'b1;
      d.rdata = '0;
      if (io_wr) begin
        case (a)
          wds_pkg::OFF_DIV_LO: d.div_n[15:0] = I_WDATA;
          wds_pkg::OFF_DIV_HI: d.div_n[31:16] = I_WDATA;
          wds_pkg::OFF_LAST: d.last = I_WDATA;
          wds_pkg::OFF_MATCH: d.match = I_WDATA;
          wds_pkg::OFF_CTRL: d.ctrl = I_WDATA[7:0] & wds_pkg::CTRL_WMASK;
          default: begin
            if (dir_wr) begin
              d.hold[dch] = I_WDATA;
              if (q.ctrl[wds_pkg::CB_AUTO]) begin
                d.outv[dch] = code16(I_WDATA,
                                     q.ctrl[wds_pkg::CB_SIGNED]);
              end
            end else if (a >= wds_pkg::OFF_ACC && a < wds_pkg::OFF_CTRL) begin
              if (!a[1]) begin
                d.alo[acc_idx(a)] = I_WDATA;
              end else if (!q.sbusy[acc_idx(a)]) begin
                ser_start[acc_idx(a)] = 1'b1;
                d.ahi[acc_idx(a)] = I_WDATA[7:0];
                d.sh[acc_idx(a)] = {I_WDATA[7:0], q.alo[acc_idx(a)]};
                d.sdi[acc_idx(a)] = I_WDATA[7];
                d.syn_n[acc_idx(a)] = 1'b0;
                d.sclk[acc_idx(a)] = 1'b0;
                d.sbusy[acc_idx(a)] = 1'b1;
                d.bitc[acc_idx(a)] = 5'(wds_pkg::SER_BITS);
              end
            end else if (a >= wds_pkg::OFF_RB && a < wds_pkg::OFF_ACC) begin
              d.rb[rb_idx(a)] = I_WDATA;
            end
          end
        endcase
      end else if (io_rd) begin
        case (a)
          wds_pkg::OFF_DIV_LO: d.rdata = q.div_n[15:0];
          wds_pkg::OFF_DIV_HI: d.rdata = q.div_n[31:16];
          wds_pkg::OFF_POS: d.rdata = q.pos;
          wds_pkg::OFF_LAST: d.rdata = q.last;
          wds_pkg::OFF_MATCH: d.rdata = q.match;
          wds_pkg::OFF_CTRL: begin
            d.rdata = {5'h00, q.sbusy, q.ctrl[7:5], |q.sbusy,
                       q.ctrl[3:0]};
          end
          default: begin
            if (a >= wds_pkg::OFF_DIRECT) begin
              d.rdata = '0;
            end else if (a >= wds_pkg::OFF_ACC && a < wds_pkg::OFF_CTRL) begin
              d.rdata = a[1] ? {!q.sbusy[acc_idx(a)], 7'h00,
                                q.ahi[acc_idx(a)]}
                             : q.alo[acc_idx(a)];
            end else if (a >= wds_pkg::OFF_RB && a < wds_pkg::OFF_ACC) begin
              d.rdata = q.rb[rb_idx(a)];
            end
          end
        endcase
      end else if (host_sram) begin
        d.saddr = I_ADDR[16:1];
        d.swd = I_WDATA;
        d.swe = I_WR_EN;
        if (!I_WR_EN) begin
          d.ack = 1'b0;
          d.hs = wds_pkg::H_SR1;
        end
      end else if (I_ADDR >= wds_pkg::FLASH_BASE &&
                   I_ADDR <= wds_pkg::FLASH_TOP && !I_ADDR[0]) begin
        // a write while the previous one is still busy is dropped
        if (!(I_WR_EN && q.fbusy)) begin
          d.ack = 1'b0;
          d.hs = wds_pkg::H_FL;
          d.wcnt = 16'(wds_pkg::FLASH_ACC_CYC);
          d.faddr = I_ADDR[13:1];
          d.fwd = I_WDATA[7:0];
          d.fwe_n = !I_WR_EN;
          d.foe_n = I_WR_EN;
          d.frd = !I_WR_EN;
          if (I_WR_EN) begin
            d.fbusy = 1'b1;
            d.fbit7 = I_WDATA[7];
            d.fto = FLASH_TIMEOUT_CYC;
          end
        end
      end
    end

    // a clear during a fetch mixes old and new offsets for one tick
    if (ctrl_wr && I_WDATA[wds_pkg::CB_CLRPOS]) begin
      d.pos = '0;
    end
    if (ctrl_wr && I_WDATA[wds_pkg::CB_ZERO]) begin
      d.hold = '0;
      d.outv = {NCH{wds_pkg::ZERO_VOLT}};
    end
    d.irq = q.ctrl[wds_pkg::CB_IRQ] &&
            ((q.pos & wds_pkg::POS_MASK) ==
             (q.match & wds_pkg::POS_MASK));
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      q <= '0;
      q.syn_n <= '1;
      q.fwe_n <= 1'b1;
      q.foe_n <= 1'b1;
      q.outv <= {NCH{wds_pkg::ZERO_VOLT}};
    end else begin
      q <= d;
    end
  end

  assign O_RDATA = q.rdata;
  assign O_ACK = q.ack;
  assign O_HOST_IRQ = q.irq;
  assign O_SRAM_ADDR = q.saddr;
  assign O_SRAM_WDATA = q.swd;
  assign O_SRAM_WE = q.swe;
  assign O_FLASH_ADDR = q.faddr;
  assign O_FLASH_WDATA = q.fwd;
  assign O_FLASH_WE_N = q.fwe_n;
  assign O_FLASH_OE_N = q.foe_n;
  assign O_CONV_SCLK = q.sclk;
  assign O_CONV_SYNC_N = q.syn_n;
  assign O_CONV_SDI = q.sdi;
  assign O_CHAN_DATA = q.outv;

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_fetch_go;
    tick && q.ctrl[wds_pkg::CB_SEQ];
  endsequence
  sequence s_fetch_body;
    q.fetch [*8] ##[40:1000] !q.fetch;
  endsequence
  sequence s_frame;
    !O_CONV_SYNC_N[0] [*8] ##[180:300] O_CONV_SYNC_N[0];
  endsequence

  a_div_restart:
  assert property (t32 && q.div_cnt == '0 && !ctrl_wr |=>
                   q.div_cnt == $past(q.div_n) + 32'd1)
    else $error("divider did not restart from divisor");
  a_tick_spacing:
  assert property (div_tick |=> !div_tick [*5])
    else $error("sample ticks closer than two reference periods");
  a_pos_clear:
  assert property (ctrl_wr && I_WDATA[wds_pkg::CB_CLRPOS] |=> q.pos == '0)
    else $error("position not cleared");
  a_zero_outputs:
  assert property (ctrl_wr && I_WDATA[wds_pkg::CB_ZERO] |=>
                   q.outv[0] == wds_pkg::ZERO_VOLT && q.hold[NCH-1] == '0)
    else $error("zero strobe did not clear outputs");
  a_auto_update:
  assert property (dir_wr && q.ctrl[wds_pkg::CB_AUTO] |=>
                   q.outv[$past(dch)] == code16($past(I_WDATA),
                   $past(q.ctrl[wds_pkg::CB_SIGNED])))
    else $error("auto update did not reach output");
  a_hold_only:
  assert property (dir_wr && !q.ctrl[wds_pkg::CB_AUTO] && !tick |=>
                   $stable(q.outv))
    else $error("output changed on a holding write");
  a_tick_update:
  assert property (tick && !dir_wr && !I_WDATA[wds_pkg::CB_ZERO] |=>
                   q.outv[0] == code16($past(q.hold[0]),
                   $past(q.ctrl[wds_pkg::CB_SIGNED])))
    else $error("tick did not move holding stage to output");
  a_fetch_run:
  assert property (s_fetch_go |=> s_fetch_body)
    else $error("fetch did not run its 48 reads");
  a_end_stop:
  assert property (seq_end && q.ctrl[wds_pkg::CB_STOP] && !ctrl_wr |=>
                   !q.ctrl[wds_pkg::CB_SEQ])
    else $error("sequencer did not stop at buffer end");
  a_irq_gate:
  assert property (!q.ctrl[wds_pkg::CB_IRQ] |=> !O_HOST_IRQ)
    else $error("interrupt raised while disabled");
  a_ser_frame:
  assert property (ser_start[0] |=> s_frame)
    else $error("serial frame length wrong");
  a_flash_lock:
  assert property (req && I_WR_EN && !I_IO_SEL && q.fbusy &&
                   I_ADDR >= wds_pkg::FLASH_BASE |=>
                   q.hs == wds_pkg::H_IDLE && O_FLASH_WE_N)
    else $error("flash write accepted while busy");
endmodule // wds_top
`default_nettype wire

// *** design/wds_pkg.sv ***
// waveform sequencer constants: register offsets, control bits, timing
// assumes a 100 MHz reference clock shared by the carrier logic
package wds_pkg;
  localparam int NCH = 48;
  localparam int NCONV = 3;
  localparam int SER_BITS = 24;
  localparam int SER_DIV = 4;
  localparam logic [6:0] OFF_DIV_LO = 7'h00;
  localparam logic [6:0] OFF_DIV_HI = 7'h02;
  localparam logic [6:0] OFF_POS = 7'h04;
  localparam logic [6:0] OFF_LAST = 7'h06;
  localparam logic [6:0] OFF_MATCH = 7'h08;
  localparam logic [6:0] OFF_RB = 7'h0a;
  localparam logic [6:0] OFF_ACC = 7'h10;
  localparam logic [6:0] OFF_CTRL = 7'h1c;
  localparam logic [6:0] OFF_DIRECT = 7'h20;
  localparam logic [17:0] SRAM_TOP = 18'h1ffff;
  localparam logic [17:0] FLASH_BASE = 18'h20000;
  localparam logic [17:0] FLASH_TOP = 18'h23ffe;
  localparam int CB_AUTO = 7;
  localparam int CB_SEQ = 6;
  localparam int CB_INT_SRC = 5;
  localparam int CB_RDBUSY = 4;
  localparam int CB_SIGNED = 3;
  localparam int CB_IRQ = 2;
  localparam int CB_STOP = 0;
  localparam int CB_RELOAD = 15;
  localparam int CB_CLRPOS = 14;
  localparam int CB_ZERO = 13;
  localparam int CB_UPD = 12;
  localparam logic [7:0] CTRL_WMASK = 8'hed;
  localparam logic [15:0] ZERO_VOLT = 16'h8000;
  localparam logic [15:0] POS_MASK = 16'h07ff;
  localparam int OSC_MHZ = 32;
  localparam int CLK_MHZ = 100;
  localparam int FLASH_WRITE_US = 200;
  localparam int FLASH_WRITE_CYC = FLASH_WRITE_US * CLK_MHZ;
  localparam int FLASH_ACC_NS = 150;
  localparam int FLASH_ACC_CYC = (FLASH_ACC_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {H_IDLE, H_SR1, H_SR2, H_FL} wds_host_t;
endpackage

// *** tb/wds_mem_model.sv ***
// far-side model: waveform sram, calibration flash and converter links
// assumes every pin is synchronous to the 100 MHz reference clock
`timescale 1ns/1ps
`default_nettype none
module wds_mem_model (
  input wire logic clk,
  input wire logic [15:0] sram_addr,
  input wire logic [15:0] sram_wdata,
  input wire logic sram_we,
  output logic [15:0] sram_rdata,
  input wire logic [12:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  output logic [7:0] flash_rdata,
  input wire logic [2:0] sync_n,
  input wire logic [2:0] sdi,
  output logic [2:0] sdo
);
  logic [15:0] sram [0:65535];
  logic [7:0] flash [0:8191];
  logic we_n_q;
  int busy;
  initial begin
    for (int i = 0; i < 65536; i++) sram[i] = 16'h0000;
    for (int i = 0; i < 8192; i++) flash[i] = 8'hff;
    sram_rdata = 16'h0000;
    flash_rdata = 8'h00;
    we_n_q = 1'b1;
    busy = 0;
    sdo = 3'b000;
  end
  // read data is valid one cycle after the address
  always @(posedge clk) begin
    if (sram_we) sram[sram_addr] <= sram_wdata;
    sram_rdata <= sram[sram_addr];
    we_n_q <= flash_we_n;
    if (!we_n_q && flash_we_n) begin
      flash[flash_addr] <= flash_wdata;
      busy <= 30;
    end else if (busy > 0) begin
      busy <= busy - 1;
    end
  end
  // a released bus toggles so a stale byte can never pass for a good one
  always @(negedge clk) begin
    if (!flash_oe_n) begin
      flash_rdata = {flash[flash_addr][7] ^ (busy > 0),
                     flash[flash_addr][6:0]};
    end else begin
      flash_rdata = ~flash_rdata;
    end
    for (int i = 0; i < 3; i++) begin
      sdo[i] = sync_n[i] ? ~sdo[i] : ~sdi[i];
    end
  end
endmodule // wds_mem_model
`default_nettype wire

// *** tb/wds_top_test.sv ***
// self-checking bench for the waveform sequencer register and memory ports
// assumes wds_mem_model answers on the sram, flash and converter pins
`timescale 1ns/1ps
`default_nettype none
module wds_top_test;
  logic clk, nrst, io_sel, mem_sel, wr_en, rd_en, ack, irq, sram_we;
  logic we_n, oe_n, sclk_q;
  logic [17:0] addr;
  logic [15:0] wdata, sram_rdata, rdata, q, sram_addr, sram_wdata;
  logic [12:0] flash_addr;
  logic [7:0] flash_rdata, flash_wdata;
  logic [2:0] sdo, sclk, sync_n, sdi;
  logic [767:0] chan;
  logic [23:0] sh;
  int mismatches, checks, nbit;
  wds_top #(.FLASH_TIMEOUT_CYC(16'h0032)) DUT (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_IO_SEL(io_sel), .I_MEM_SEL(mem_sel),
    .I_WR_EN(wr_en), .I_RD_EN(rd_en), .I_ADDR(addr), .I_WDATA(wdata),
    .I_SRAM_RDATA(sram_rdata), .I_FLASH_RDATA(flash_rdata),
    .I_CONV_SDO(sdo), .O_RDATA(rdata), .O_ACK(ack), .O_HOST_IRQ(irq),
    .O_SRAM_ADDR(sram_addr), .O_SRAM_WDATA(sram_wdata), .O_SRAM_WE(sram_we),
    .O_FLASH_ADDR(flash_addr), .O_FLASH_WDATA(flash_wdata),
    .O_FLASH_WE_N(we_n), .O_FLASH_OE_N(oe_n), .O_CONV_SCLK(sclk),
    .O_CONV_SYNC_N(sync_n), .O_CONV_SDI(sdi), .O_CHAN_DATA(chan));
  wds_mem_model mem (
    .clk(clk), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
    .sram_we(sram_we), .sram_rdata(sram_rdata), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_rdata(flash_rdata), .sync_n(sync_n), .sdi(sdi), .sdo(sdo));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic final_report;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic hang;
    mismatches++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    final_report;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobes are one-cycle pulses, the answer is awaited afterwards
  task automatic acc(input logic io, input logic wr, input logic [17:0] a,
                     input logic [15:0] d);
    int n;
    @(negedge clk);
    io_sel = io;
    mem_sel = !io;
    wr_en = wr;
    rd_en = !wr;
    addr = a;
    wdata = d;
    @(negedge clk);
    io_sel = 1'b0;
    mem_sel = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    n = 0;
    while (ack !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) hang();
    q = rdata;
  endtask
  task automatic wr(input logic io, input logic [17:0] a, input logic [15:0] d);
    acc(io, 1'b1, a, d);
  endtask
  task automatic rd(input logic io, input logic [17:0] a, input logic [15:0] m,
                    input logic [15:0] e);
    acc(io, 1'b0, a, 16'h0000);
    chk(q & m, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  always @(negedge clk) begin
    if (sclk[0] && !sclk_q) begin
      sh = {sh[22:0], sdi[0]};
      nbit++;
    end
    sclk_q = sclk[0];
  end
  initial begin
    {io_sel, mem_sel, wr_en, rd_en, nrst, sclk_q} = 6'h00;
    addr = 18'h00000;
    wdata = 16'h0000;
    sh = 24'h000000;
    {mismatches, checks, nbit} = {32'h0, 32'h0, 32'h0};
    idle(5);
    nrst = 1'b1;
    rd(1, 18'h1c, 16'hffff, 16'h0000);
    rd(1, 18'h04, 16'hffff, 16'h0000);
    chk(chan[15:0], 16'h8000);
    wr(1, 18'h1c, 16'h0088);
    wr(1, 18'h2a, 16'h7fff);
    idle(2);
    chk(chan[80 +: 16], 16'hffff);
    wr(1, 18'h1c, 16'h0000);
    wr(1, 18'h2a, 16'h1234);
    idle(2);
    chk(chan[80 +: 16], 16'hffff);
    wr(1, 18'h1c, 16'h1000);
    idle(2);
    chk(chan[80 +: 16], 16'h1234);
    wr(1, 18'h1c, 16'h2000);
    idle(2);
    chk(chan[80 +: 16], 16'h8000);
    for (int p = 0; p < 2; p++) begin
      wr(0, {1'b0, 6'd0, 10'(p), 1'b0}, 16'h1100 + 16'(p));
      wr(0, {1'b0, 6'd47, 10'(p), 1'b0}, 16'h4700 + 16'(p));
    end
    wr(0, 18'h1fffe, 16'hbeef);
    wr(1, 18'h06, 16'h0001);
    rd(1, 18'h06, 16'h07ff, 16'h0001);
    wr(1, 18'h08, 16'h0001);
    wr(1, 18'h1c, 16'h0045);
    wr(1, 18'h1c, 16'h1045);
    rd(0, 18'h1fffe, 16'hffff, 16'hbeef);
    idle(80);
    rd(1, 18'h04, 16'h07ff, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    wr(1, 18'h1c, 16'h1045);
    idle(80);
    chk(chan[15:0], 16'h1100);
    chk(chan[767 -: 16], 16'h4700);
    rd(1, 18'h1c, 16'h0040, 16'h0000);
    wr(1, 18'h1c, 16'h1005);
    idle(80);
    chk(chan[15:0], 16'h1101);
    wr(1, 18'h1c, 16'h4000);
    rd(1, 18'h04, 16'h07ff, 16'h0000);
    wr(1, 18'h00, 16'd620);
    wr(1, 18'h02, 16'h0000);
    rd(1, 18'h00, 16'hffff, 16'd620);
    wr(1, 18'h06, 16'h0002);
    wr(1, 18'h1c, 16'h8060);
    idle(10000);
    wr(1, 18'h1c, 16'h0000);
    rd(1, 18'h04, 16'h07ff, 16'h0002);
    wr(0, 18'h20010, 16'h005a);
    acc(0, 1'b0, 18'h20010, 16'h0000);
    chk({15'h0000, q[7]}, 16'h0001);
    for (int i = 0; i < 10 && q[7] !== 1'b0; i++) begin
      acc(0, 1'b0, 18'h20010, 16'h0000);
    end
    chk({8'h00, q[7:0]}, 16'h005a);
    wr(1, 18'h10, 16'h5a3c);
    wr(1, 18'h12, 16'h00c3);
    rd(1, 18'h12, 16'h80ff, 16'h00c3);
    rd(1, 18'h1c, 16'h0110, 16'h0110);
    for (int i = 0; i < 400 && sync_n[0] !== 1'b1; i++) idle(1);
    if (sync_n[0] !== 1'b1) hang();
    idle(2);
    chk(16'(nbit), 16'd24);
    chk(sh[23:8], 16'hc35a);
    chk({8'h00, sh[7:0]}, 16'h003c);
    rd(1, 18'h12, 16'h8000, 16'h8000);
    rd(1, 18'h0a, 16'hffff, 16'ha5c3);
    final_report;
  end
endmodule // wds_top_test
`default_nettype wire
